// *** include/mii_status_defs.vh ***
// constants for the quad mii receive status and management block
`ifndef MII_STATUS_DEFS_VH
`define MII_STATUS_DEFS_VH

`define MCLK_PERIOD_PS 8000
`define RXCLK_100_PS 40000
`define RXCLK_10_PS 400000
// receive clock periods in mclk cycles
`define RXCLK_100_DIV (`RXCLK_100_PS / `MCLK_PERIOD_PS)
`define RXCLK_10_DIV (`RXCLK_10_PS / `MCLK_PERIOD_PS)
// cycles after reset in which the pins load their register defaults
`define INIT_CYCLES 2'h3

`define REG_CTRL 5'h00
`define REG_STAT 5'h01
`define REG_ID1 5'h02
`define REG_ID2 5'h03
`define REG_ADV 5'h04
`define REG_LPA 5'h05
`define REG_EXP 5'h06
`define REG_FIRST_HI 5'h10
`define REG_LAST_HI 5'h14
`define REG_INT_STAT 5'h12

`define CTRL_SPEED 13
`define CTRL_ISOLATE 10
`define CTRL_DUPLEX 8
`define CTRL_RESET 16'h3000
`define STAT_LINK 2
`define STAT_BASE 16'h7809
`define INT_STAT_BIT 2

`define OP_WRITE 2'h1
`define OP_READ 2'h2
`define PREAMBLE_MIN 6'h20
`define FRAME_BITS 6'h20

`endif

// *** design/mdio_slave.v ***
// serial management frame engine: clause 22 frames sampled on mdc rises
`timescale 1ns/1ps
`include "mii_status_defs.vh"
module mdio_slave #(
  parameter PHY_ADDR_HI = 3'h0
) (
  // clock and reset
  input wire mclk,
  input wire resetn,
  input wire ce,
  // synchronised management pins
  input wire mdc_rise,
  input wire mdc_fall,
  input wire mdio_in,
  output reg mdio_out,
  output reg mdio_oe,
  // register access
  output reg [1:0] acc_port,
  output reg [4:0] acc_reg,
  output reg [15:0] wr_data,
  output reg wr_stb,
  output reg rd_stb,
  input wire [15:0] rd_data
);
  localparam S_IDLE = 3'b001;
  localparam S_HDR = 3'b010;
  localparam S_DATA = 3'b100;
  reg [2:0] state;
  reg [5:0] ones;
  reg [5:0] cnt;
  reg [15:0] shreg;
  reg [1:0] op;
  reg ours;
  reg [15:0] rd_shift;
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      ones <= 6'h00;
      cnt <= 6'h00;
      shreg <= 16'h0000;
      op <= 2'h0;
      ours <= 1'b0;
      acc_port <= 2'h0;
      acc_reg <= 5'h00;
      wr_data <= 16'h0000;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      rd_shift <= 16'h0000;
      mdio_out <= 1'b0;
      mdio_oe <= 1'b0;
    end else if (ce) begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      if (mdc_rise) begin
        shreg <= {shreg[14:0], mdio_in};
        case (state)
          S_IDLE: begin
            if (mdio_in) begin
              if (ones != 6'h3f) ones <= ones + 6'h01;
            end else begin
              if (ones >= `PREAMBLE_MIN) begin
                state <= S_HDR;
                cnt <= 6'h01;
              end
              ones <= 6'h00;
            end
          end
          S_HDR: begin
            cnt <= cnt + 6'h01;
            if (cnt == 6'h01 && !mdio_in) state <= S_IDLE;
            if (cnt == 6'h03) op <= {shreg[0], mdio_in};
            if (cnt == 6'h0d) begin
              ours <= (shreg[8:6] == PHY_ADDR_HI) && (op == `OP_READ || op == `OP_WRITE);
              acc_reg <= {shreg[3:0], mdio_in};
              acc_port <= shreg[5:4];
            end
            if (cnt == 6'h0f) begin
              state <= S_DATA;
              cnt <= 6'h00;
            end
          end
          S_DATA: begin
            cnt <= cnt + 6'h01;
            if (cnt == 6'h0f) begin
              if (ours && op == `OP_WRITE) begin
                wr_data <= {shreg[14:0], mdio_in};
                wr_stb <= 1'b1;
              end
              state <= S_IDLE;
            end
          end
          default: state <= S_IDLE;
        endcase
      end
      if (mdc_fall) begin
        // drive only from the second turnaround bit; the first belongs to the released line
        if (state == S_HDR && cnt == 6'h0f && ours && op == `OP_READ) begin
          mdio_oe <= 1'b1;
          mdio_out <= 1'b0;
          // strobe and capture share an edge, so a clear on read still returns the old bit
          rd_shift <= rd_data;
          rd_stb <= 1'b1;
        end else if (state == S_DATA && ours && op == `OP_READ) begin
          mdio_oe <= 1'b1;
          mdio_out <= rd_shift[15];
          rd_shift <= {rd_shift[14:0], 1'b0};
        end else begin
          mdio_oe <= 1'b0;
        end
      end
    end
  end
endmodule

// *** design/quad_mii_status.v ***
// four-port mii receive status outputs with shared serial management
//
// Overview of operation
// - rx valid high, on the receive clock, only for valid code groups
// - rx error high on invalid code group or unlocked pll
// - receive clock is 25 MHz at 100 Mbps, 2.5 MHz at 10 Mbps
// - collision output high for as long as collision lasts
// - collision output not clock aligned, held low in full duplex
// - half duplex: carrier sense on transmit or receive activity
// - full duplex: carrier sense on receive activity only
// - one bidirectional serial data line serves management of all ports
// - open-drain interrupt pulled low on a status change
// - interrupt released after reading register 1 then register 18
// - lockout high: management read only, pins drive their bits
// - lockout low: pins set defaults at reset, then writes control
// - isolate pin drives isolate bit; set bit isolates port data
// - lockout high: isolate pin continuously controls isolate bit
// - lockout low: isolate pin loads isolate default, writes then control
// - registers 0 to 3 and 18 exist, sixteen bits each; all other addresses read zero
// - receive data is a four-bit nibble on the receive clock
`timescale 1ns/1ps
`include "mii_status_defs.vh"
module quad_mii_status #(
  parameter PORTS = 4,
  parameter PHY_ADDR_HI = 3'h0,
  parameter [15:0] ID_HI = 16'h1234, // arbitrary identification value
  parameter [15:0] ID_LO = 16'h5670  // arbitrary identification value
) (
  // clock and reset
  input wire mclk,
  input wire resetn,
  input wire ce,
  // receive path from the decoder, per port
  input wire [4*PORTS-1:0] rx_nibble,
  input wire [PORTS-1:0] rx_word_valid,
  output wire [PORTS-1:0] rx_word_ready,
  input wire [PORTS-1:0] rx_code_bad,
  input wire [PORTS-1:0] pll_locked,
  input wire [PORTS-1:0] rx_active,
  input wire [PORTS-1:0] tx_active,
  input wire [PORTS-1:0] link_up,
  // mac facing
  output wire [4*PORTS-1:0] rxd,
  output wire [PORTS-1:0] rx_dv,
  output wire [PORTS-1:0] rx_er,
  output wire [PORTS-1:0] rx_clk,
  output wire [PORTS-1:0] col,
  output wire [PORTS-1:0] crs,
  output wire [PORTS-1:0] rx_oe,
  // management pins
  input wire mdc,
  input wire mdio_in,
  output wire mdio_out,
  output wire mdio_oe,
  output wire mgmt_status_irq_n,
  output wire mgmt_status_irq_oe,
  input wire mgmt_write_lockout,
  input wire [PORTS-1:0] port_isolate_pin,
  input wire [PORTS-1:0] speed_pin,
  input wire [PORTS-1:0] duplex_pin
);
  // pin synchronisers
  reg [1:0] mdc_s;
  reg [1:0] mdio_s;
  reg [1:0] lock_s;
  reg mdc_d;
  reg [PORTS-1:0] iso_s1, iso_s2, spd_s1, spd_s2, dup_s1, dup_s2;
  reg [1:0] init_cnt;
  // pin defaults wait until the synchronisers hold real pin levels, not their reset zeros
  wire init_done = (init_cnt == `INIT_CYCLES);
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mdc_s <= 2'h0;
      mdio_s <= 2'h0;
      lock_s <= 2'h0;
      mdc_d <= 1'b0;
      iso_s1 <= {PORTS{1'b0}};
      iso_s2 <= {PORTS{1'b0}};
      spd_s1 <= {PORTS{1'b0}};
      spd_s2 <= {PORTS{1'b0}};
      dup_s1 <= {PORTS{1'b0}};
      dup_s2 <= {PORTS{1'b0}};
      init_cnt <= 2'h0;
    end else if (ce) begin
      mdc_s <= {mdc_s[0], mdc};
      mdio_s <= {mdio_s[0], mdio_in};
      lock_s <= {lock_s[0], mgmt_write_lockout};
      mdc_d <= mdc_s[1];
      iso_s1 <= port_isolate_pin;
      iso_s2 <= iso_s1;
      spd_s1 <= speed_pin;
      spd_s2 <= spd_s1;
      dup_s1 <= duplex_pin;
      dup_s2 <= dup_s1;
      if (!init_done) init_cnt <= init_cnt + 2'h1;
    end
  end
  wire mdc_rise = mdc_s[1] & ~mdc_d;
  wire mdc_fall = ~mdc_s[1] & mdc_d;
  wire lockout = lock_s[1];

  wire [1:0] acc_port;
  wire [4:0] acc_reg;
  wire [15:0] wr_data;
  wire wr_stb;
  wire rd_stb;
  reg [15:0] rd_data;

  mdio_slave #(.PHY_ADDR_HI(PHY_ADDR_HI)) u_mdio (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .mdc_rise(mdc_rise),
    .mdc_fall(mdc_fall),
    .mdio_in(mdio_s[1]),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .acc_port(acc_port),
    .acc_reg(acc_reg),
    .wr_data(wr_data),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .rd_data(rd_data)
  );

  // per-port register state and receive status
  wire [16*PORTS-1:0] ctrl_bus;
  localparam integer DIV_FAST = `RXCLK_100_DIV;
  localparam integer DIV_SLOW = `RXCLK_10_DIV;
  wire [PORTS-1:0] int_stat;
  // stage irq clear: a read of register 1 arms, a read of register 18 clears
  reg [PORTS-1:0] clr_armed;

  genvar p;
  generate
    for (p = 0; p < PORTS; p = p + 1) begin : g_port
      reg [15:0] ctrl;
      reg link_d;
      reg istat;
      reg [15:0] div_cnt;
      reg rclk;
      reg [3:0] buf_d0, buf_d1;
      reg buf_v0, buf_v1;
      reg [3:0] out_d;
      reg dv, er;
      wire hit = (acc_port == p);
      wire speed100 = ctrl[`CTRL_SPEED];
      wire full_dup = ctrl[`CTRL_DUPLEX];
      wire [15:0] period = speed100 ? DIV_FAST[15:0] : DIV_SLOW[15:0];
      wire rclk_rise = (div_cnt >= period - 16'h0001);
      wire pop = rclk_rise & buf_v0;
      always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          ctrl <= `CTRL_RESET;
          link_d <= 1'b0;
          istat <= 1'b0;
        end else if (ce) begin
          link_d <= link_up[p];
          if (!init_done) begin
            // defaults loaded from pins after reset release
            ctrl[`CTRL_ISOLATE] <= iso_s2[p];
            ctrl[`CTRL_SPEED] <= spd_s2[p];
            ctrl[`CTRL_DUPLEX] <= dup_s2[p];
          end else if (lockout) begin
            ctrl[`CTRL_ISOLATE] <= iso_s2[p];
            ctrl[`CTRL_SPEED] <= spd_s2[p];
            ctrl[`CTRL_DUPLEX] <= dup_s2[p];
          end else if (wr_stb && hit && acc_reg == `REG_CTRL) begin
            ctrl <= wr_data;
          end
          // set wins over the clear
          if (link_up[p] != link_d) istat <= 1'b1;
          else if (rd_stb && hit && acc_reg == `REG_INT_STAT && clr_armed[p]) istat <= 1'b0;
        end
      end
      // receive clock divider
      always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          div_cnt <= 16'h0000;
          rclk <= 1'b0;
        end else if (ce) begin
          if (rclk_rise) begin
            div_cnt <= 16'h0000;
            rclk <= 1'b1;
          end else begin
            div_cnt <= div_cnt + 16'h0001;
            // an odd period gives the extra cycle to the low phase
            if (div_cnt == (period >> 1) - 16'h0001) rclk <= 1'b0;
          end
        end
      end
      // two-entry buffer between decoder and receive clock
      assign rx_word_ready[p] = ~buf_v1;
      always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          buf_d0 <= 4'h0;
          buf_d1 <= 4'h0;
          buf_v0 <= 1'b0;
          buf_v1 <= 1'b0;
          out_d <= 4'h0;
          dv <= 1'b0;
          er <= 1'b0;
        end else if (ce) begin
          if (pop) begin
            buf_d0 <= buf_d1;
            buf_v0 <= buf_v1 | (rx_word_valid[p] & buf_v0);
            buf_v1 <= 1'b0;
            if (rx_word_valid[p] & ~buf_v1) begin
              if (buf_v1) buf_d0 <= buf_d1;
              else buf_d0 <= rx_nibble[4*p +: 4];
              buf_v0 <= 1'b1;
            end
          end else if (rx_word_valid[p] & ~buf_v1) begin
            if (buf_v0) begin
              buf_d1 <= rx_nibble[4*p +: 4];
              buf_v1 <= 1'b1;
            end else begin
              buf_d0 <= rx_nibble[4*p +: 4];
              buf_v0 <= 1'b1;
            end
          end
          if (rclk_rise) begin
            out_d <= buf_d0;
            dv <= pop & ~rx_code_bad[p];
            er <= (pop & rx_code_bad[p]) | ~pll_locked[p];
          end
        end
      end
      assign rxd[4*p +: 4] = out_d;
      assign rx_dv[p] = dv;
      assign rx_er[p] = er;
      assign rx_clk[p] = rclk;
      // combinational, not tied to any mii clock
      assign col[p] = ~full_dup & tx_active[p] & rx_active[p];
      assign crs[p] = full_dup ? rx_active[p] : (rx_active[p] | tx_active[p]);
      assign rx_oe[p] = ~ctrl[`CTRL_ISOLATE];
      assign ctrl_bus[16*p +: 16] = ctrl;
      assign int_stat[p] = istat;
    end
  endgenerate

  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clr_armed <= {PORTS{1'b0}};
    end else if (ce && rd_stb) begin
      if (acc_reg == `REG_STAT) clr_armed[acc_port] <= 1'b1;
      else if (acc_reg == `REG_INT_STAT) clr_armed[acc_port] <= 1'b0;
      else clr_armed[acc_port] <= 1'b0;
    end
  end

  // read mux; lockout leaves reads intact and blocks writes above
  always @* begin
    case (acc_reg)
      `REG_CTRL: rd_data = ctrl_bus[16*acc_port +: 16];
      `REG_STAT: rd_data = `STAT_BASE | ({15'h0000, link_up[acc_port]} << `STAT_LINK);
      `REG_ID1: rd_data = ID_HI;
      `REG_ID2: rd_data = ID_LO;
      `REG_INT_STAT: rd_data = {15'h0000, int_stat[acc_port]} << `INT_STAT_BIT;
      default: rd_data = 16'h0000;
    endcase
  end

  // open drain: only ever drive low
  assign mgmt_status_irq_n = 1'b0;
  assign mgmt_status_irq_oe = |int_stat;
endmodule

// *** testbench/quad_mii_status_asserts.sv ***
// port assertions for the quad mii status block
`timescale 1ns/1ps
module quad_mii_status_asserts #(
  parameter PORTS = 4
) (
  // clock and reset
  input wire mclk,
  input wire resetn,
  // pins and levels
  input wire mgmt_write_lockout,
  input wire mdc,
  input wire [PORTS-1:0] rx_active,
  input wire [PORTS-1:0] tx_active,
  input wire [PORTS-1:0] link_up,
  input wire [PORTS-1:0] duplex_pin,
  input wire [PORTS-1:0] speed_pin,
  input wire [PORTS-1:0] port_isolate_pin,
  // outputs
  input wire mdio_oe,
  input wire mgmt_status_irq_oe,
  input wire [PORTS-1:0] rx_dv,
  input wire [PORTS-1:0] rx_clk,
  input wire [PORTS-1:0] col,
  input wire [PORTS-1:0] crs,
  input wire [PORTS-1:0] rx_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // pins only rule the bits once lockout and pin have settled through the synchronisers
  property p_crs_rx; rx_active[2] |-> crs[2]; endproperty
  a_crs_rx: assert property (p_crs_rx) else $error("crs low with receive activity");
  property p_crs_full;
    mgmt_write_lockout && $past(mgmt_write_lockout, 4) && duplex_pin[2] && $past(duplex_pin[2], 4)
      && !rx_active[2] |-> !crs[2];
  endproperty
  a_crs_full: assert property (p_crs_full) else $error("crs from transmit in full duplex");
  property p_col_full;
    mgmt_write_lockout && $past(mgmt_write_lockout, 4) && duplex_pin[2] && $past(duplex_pin[2], 4) |-> !col[2];
  endproperty
  a_col_full: assert property (p_col_full) else $error("collision in full duplex");
  property p_col_half;
    mgmt_write_lockout && $past(mgmt_write_lockout, 4) && !duplex_pin[2] && !$past(duplex_pin[2], 4)
      && rx_active[2] && tx_active[2] |-> col[2];
  endproperty
  a_col_half: assert property (p_col_half) else $error("collision not shown");
  property p_dv_clk; $changed(rx_dv[0]) |-> rx_clk[0]; endproperty
  a_dv_clk: assert property (p_dv_clk) else $error("rx valid moved off the receive clock");
  property p_clk100;
    mgmt_write_lockout && speed_pin[0] && $past(speed_pin[0], 4) && $rose(rx_clk[0])
      |=> rx_clk[0] ##1 !rx_clk[0] [*3] ##1 rx_clk[0];
  endproperty
  a_clk100: assert property (p_clk100) else $error("fast receive clock period wrong");
  property p_irq_set; $changed(link_up[0]) |-> ##[1:6] mgmt_status_irq_oe; endproperty
  a_irq_set: assert property (p_irq_set) else $error("no interrupt on status change");
  property p_iso;
    mgmt_write_lockout && $past(mgmt_write_lockout, 4) && port_isolate_pin[3] && $past(port_isolate_pin[3], 4)
      |-> !rx_oe[3];
  endproperty
  a_iso: assert property (p_iso) else $error("isolate pin not followed");
  property p_oe_turn; $rose(mdio_oe) |-> !mdc; endproperty
  a_oe_turn: assert property (p_oe_turn) else $error("mdio drive began off the low phase");
  property p_reset; $rose(resetn) |-> &rx_oe && !mgmt_status_irq_oe; endproperty
  a_reset: assert property (p_reset) else $error("wrong levels out of reset");
endmodule
bind quad_mii_status quad_mii_status_asserts #(.PORTS(PORTS)) u_chk (.*);

// *** testbench/mgmt_station.sv ***
// station manager model: clause 22 frames on mdc and mdio
`timescale 1ns/1ps
`include "mii_status_defs.vh"
module mgmt_station (
  // management pins
  output logic mdc = 1'b0,
  output logic drv = 1'b1,
  output logic en = 1'b0,
  input wire mdio
);
  // data changes after the fall and is taken at the rise; mdc stands low between frames
  task automatic shift(input logic b, output logic s);
    drv = b;
    // 200 ns half periods keep mdc at 2.5 MHz
    #200 mdc = 1'b1;
    s = mdio;
    #200 mdc = 1'b0;
  endtask
  task automatic frame(input logic rd, input logic [9:0] ar, input logic [15:0] wd, output logic [15:0] q);
    logic s;
    logic [13:0] hd;
    hd = {2'b01, rd ? `OP_READ : `OP_WRITE, ar};
    #3;
    en = 1'b1;
    repeat (32) shift(1'b1, s);
    for (int i = 13; i >= 0; i--) shift(hd[i], s);
    // a read hands the line over for the turnaround and the data
    en = !rd;
    shift(1'b1, s);
    shift(1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      shift(wd[i], s);
      q[i] = s;
    end
    en = 1'b0;
  endtask
endmodule

// *** testbench/tb.sv ***
// self-checking bench for the quad mii status block
`timescale 1ns/1ps
`include "mii_status_defs.vh"
module tb;
  logic mclk = 0;
  logic resetn = 0;
  logic [15:0] rx_nibble = 0;
  logic [3:0] rx_word_valid = 0, rx_code_bad = 0, pll_locked = 4'hf, rx_active = 0, tx_active = 0, link_up = 0;
  logic mgmt_write_lockout = 0;
  logic ce = 1;
  logic [3:0] port_isolate_pin = 0, speed_pin = 4'hf, duplex_pin = 0;
  wire [15:0] rxd;
  wire [3:0] rx_word_ready, rx_dv, rx_er, rx_clk, col, crs, rx_oe;
  wire mdc, st_drv, st_en, mdio_out, mdio_oe, mgmt_status_irq_n, mgmt_status_irq_oe;
  // mdio has a pull-up, so a released line reads high
  wire mdio_in = mdio_oe ? mdio_out : (st_en ? st_drv : 1'b1);
  int bad_count = 0;
  int n_tests = 0;
  int stall = 0;
  logic [15:0] q;
  logic [3:0] e;
  logic [3:0] got[$];
  realtime t;
  always #4 mclk = ~mclk;
  quad_mii_status #(.ID_HI(16'h0abc)) u_dut (.*); // id value arbitrary
  mgmt_station u_st (.mdc(mdc), .drv(st_drv), .en(st_en), .mdio(mdio_in));
  always @(negedge rx_clk[0]) if (rx_dv[0]) got.push_back(rxd[3:0]);
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic mg(input logic rd, input logic [1:0] p, input logic [4:0] r, input logic [15:0] d);
    u_st.frame(rd, {3'h0, p, r}, d, q);
  endtask
  task automatic pause(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic push(input logic [3:0] v);
    rx_nibble[3:0] = v;
    rx_word_valid[0] = 1;
    while (!rx_word_ready[0]) begin
      stall++;
      @(negedge mclk);
    end
    @(negedge mclk);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #400000;
    bad_count++;
    print_verdict;
  end
  initial begin
    pause(5);
    chk("rx_oe", 4'hf, rx_oe);
    chk("irq_oe", 0, mgmt_status_irq_oe);
    resetn = 1;
    pause(8);
    mg(0, 1, `REG_CTRL, 16'h1 << `CTRL_ISOLATE);
    pause(6);
    chk("rx_oe", 4'hd, rx_oe);
    mg(1, 1, `REG_CTRL, 0);
    chk("reg0", 16'h1 << `CTRL_ISOLATE, q);
    mg(1, 0, `REG_ID1, 0);
    chk("id", 16'h0abc, q);
    $display("test writes done");
    link_up[0] = 1;
    pause(8);
    chk("irq set", 1, mgmt_status_irq_oe);
    mg(1, 0, `REG_INT_STAT, 0);
    chk("irq held", 1, mgmt_status_irq_oe);
    chk("int bit", 1, q[`INT_STAT_BIT]);
    mg(1, 0, `REG_STAT, 0);
    chk("link", 1, q[`STAT_LINK]);
    mg(1, 0, `REG_INT_STAT, 0);
    chk("int read", 1, q[`INT_STAT_BIT]);
    pause(6);
    chk("irq clear", 0, mgmt_status_irq_oe);
    $display("test interrupt done");
    // clock enable low must freeze the receive clocks
    ce = 0;
    e = rx_clk;
    pause(12);
    chk("frozen", e, rx_clk);
    ce = 1;
    mgmt_write_lockout = 1;
    port_isolate_pin = 4'h8;
    pause(6);
    mg(0, 2, `REG_CTRL, 16'h1 << `CTRL_ISOLATE);
    pause(6);
    chk("rx_oe", 4'h7, rx_oe);
    $display("test lockout done");
    for (int i = 0; i < 8; i++) begin
      duplex_pin = {4{i[2]}};
      rx_active = {1'b0, i[0], 2'b0};
      tx_active = {1'b0, i[1], 2'b0};
      pause(6);
      e = {1'b0, i[0] | (i[1] & !i[2]), 2'b0};
      chk("crs", e, crs);
      e = {1'b0, i[0] & i[1] & !i[2], 2'b0};
      chk("col", e, col);
    end
    $display("test carrier done");
    speed_pin[1] = 0;
    pause(120);
    @(posedge rx_clk[1]);
    t = $realtime;
    @(posedge rx_clk[1]);
    chk("slow period", 16'd400, 16'($rtoi($realtime - t)));
    @(posedge rx_clk[0]);
    t = $realtime;
    @(posedge rx_clk[0]);
    chk("fast period", 16'h0028, 16'($rtoi($realtime - t)));
    $display("test clock done");
    @(negedge mclk);
    // the decoder outpaces the receive clock, so the buffer fills and refuses
    for (int i = 1; i <= 6; i++) push(4'(i));
    rx_word_valid[0] = 0;
    pause(60);
    chk("refused", 1, stall > 0);
    chk("count", 6, 16'(got.size()));
    for (int i = 0; i < 6; i++) chk("rxd", 4'(i + 1), got[i]);
    pll_locked[0] = 0;
    pause(12);
    chk("rx_er", 4'h1, rx_er);
    $display("test receive done");
    print_verdict;
  end
endmodule
